// file: verif/mrc_host_model.sv
// Host-side model driving the direction pin
`timescale 1ns/10ps
`default_nettype none
module mrc_host_model
(
  input wire logic hclk,
  input wire logic supply_ok,
  input wire logic dir_want,
  output logic direction_pin
);
  // Pin forced low until logic supply is up, again after any dip
  always_ff @(posedge hclk)
  begin
    direction_pin <= supply_ok & dir_want;
  end
endmodule
`default_nettype wire

// file: verif/test_motor_run_control_fault_readback.sv
// Testbench for the run-control bank with fault readback
`timescale 1ns/10ps
`default_nettype none
module test_motor_run_control_fault_readback;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] flt = 6'h0;
  logic supply_ok = 1'b0;
  logic dir_want = 1'b0;
  logic speed_cmd = 1'b0;
  logic hresp;
  logic [31:0] hrdata;
  logic hreadyout;
  logic direction_pin;
  logic motor_forward;
  logic excitation_en;
  logic run_start;
  logic irq;
  logic [31:0] rd;
  int err_total = 0;
  int check_count = 0;
  int pulses = 0;
  int p0;
  always #4 hclk = ~hclk;
  always @(posedge hclk)
  begin
    if (run_start === 1'b1)
      pulses++;
  end
  mrc_host_model host (.hclk(hclk), .supply_ok(supply_ok), .dir_want(dir_want),
    .direction_pin(direction_pin));
  mrc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .direction_pin(direction_pin),
    .general_fault_flag(flt[5]), .supply_reset_flag(flt[4]), .storage_fault_flag(flt[3]),
    .timeout_expiry_flag(flt[2]), .soft_current_limit_flag(flt[1]),
    .nvm_write_limit_flag(flt[0]), .motor_forward(motor_forward),
    .excitation_en(excitation_en), .run_start(run_start), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Called just after a rising edge; hready is judged at each rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_dir;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 32'h7C, {30'h0, i[0], 1'b0});
      dir_want <= i[1];
      repeat (8) @(posedge hclk);
      chk("motor_forward", {31'h0, i[0] ~^ i[1]}, {31'h0, motor_forward});
      bus(1'b0, 32'h7C, 32'h0);
      chk("run_reg", {30'h0, i[0], 1'b0}, rd);
    end
  endtask
  task automatic t_run;
    p0 = pulses;
    bus(1'b1, 32'h7C, 32'h1);
    speed_cmd <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("excitation_on", 32'h1, {31'h0, excitation_en});
    bus(1'b1, 32'h7C, 32'h1);
    repeat (2) @(posedge hclk);
    chk("start_pulses", 32'h1, pulses - p0);
    // Host lowers the speed command before it stops the motor
    speed_cmd <= 1'b0;
    @(posedge hclk);
    chk("speed_low", 32'h0, {31'h0, speed_cmd});
    bus(1'b1, 32'h7C, 32'h0);
    repeat (2) @(posedge hclk);
    chk("excitation_off", 32'h0, {31'h0, excitation_en});
  endtask
  task automatic t_fault;
    bus(1'b1, 32'h84, 32'h3F);
    for (int i = 0; i < 6; i++)
    begin
      // Ones in 15:10 must not stick
      bus(1'b1, i * 4, 32'hFFFF ^ i);
      flt <= 6'h20 >> i;
      repeat (8) @(posedge hclk);
      bus(1'b0, i * 4, 32'h0);
      chk("dev_reg", {16'h0, 6'h20 >> i, 10'h3FF ^ i[9:0]}, rd);
      chk("irq_on", 32'h1, {31'h0, irq});
      bus(1'b0, 32'h80, 32'h0);
      chk("status", {26'h0, 6'h20 >> i}, rd);
      flt <= 6'h0;
      repeat (8) @(posedge hclk);
      bus(1'b1, 32'h88, 32'h3F);
      bus(1'b0, i * 4, 32'h0);
      chk("dev_reg_clear", {22'h0, 10'h3FF ^ i[9:0]}, rd);
      chk("irq_off", 32'h0, {31'h0, irq});
    end
    bus(1'b1, 32'h84, 32'h0);
    flt <= 6'h01;
    repeat (8) @(posedge hclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b0, 32'h80, 32'h0);
    chk("status_masked", 32'h1, rd);
    flt <= 6'h0;
    bus(1'b1, 32'h100, 32'h155);
    bus(1'b0, 32'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Supply dip: host pins and device clear go low together, then come back
  task automatic t_glitch;
    supply_ok <= 1'b0;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    chk("pin_held_low", 32'h0, {31'h0, direction_pin});
    chk("dip_exc", 32'h0, {31'h0, excitation_en});
    hresetn <= 1'b1;
    supply_ok <= 1'b1;
    @(posedge hclk);
    chk("dip_fwd", 32'h1, {31'h0, motor_forward});
    chk("dip_irq", 32'h0, {31'h0, irq});
    repeat (8) @(posedge hclk);
    chk("dip_reverse", 32'h0, {31'h0, motor_forward});
    bus(1'b0, 32'h80, 32'h0);
    chk("dip_status", 32'h0, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    err_total++;
    complete_run;
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    supply_ok <= 1'b1;
    @(posedge hclk);
    chk("reset_fwd", 32'h1, {31'h0, motor_forward});
    chk("reset_exc", 32'h0, {31'h0, excitation_en});
    chk("reset_irq", 32'h0, {31'h0, irq});
    t_dir;
    t_run;
    t_fault;
    t_glitch;
    complete_run;
  end
endmodule
`default_nettype wire

// file: verilog/mrc_defines.svh
// Constants for the motor run-control and fault readback block
// Overview of operation
// - Rotation is forward when direction bit equals direction pin, else reverse.
// - Run bit 0 stops excitation; setting it to 1 starts a run sequence.
// - Every read of registers 0 to 31 returns the critical fault flags in bits 15 to 10.
// - Every read of registers 0 to 31 returns that register's own settings in bits 9 to 0.
// - Fault field order: general, supply reset, memory, timeout, overcurrent, write limit.
// - A fault flag reads 1 while its fault is detected, 0 otherwise.
// - In the run-control register, run is bit 0 and direction is bit 1.
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
`define MRC_IDX_W 6
`define MRC_DEV_REGS 32
`define MRC_SET_W 10
`define MRC_FLT_W 6
`define MRC_IDX_RUN 6'h1F
`define MRC_IDX_STS 6'h20
`define MRC_IDX_EN 6'h21
`define MRC_IDX_CLR 6'h22
`define MRC_RUN_BIT 0
`define MRC_DIR_BIT 1
`define MRC_FLT_LSB 10
`define MRC_FLT_MSB 15
`define MRC_HTRANS_NONSEQ 2'h2
`endif

// file: verilog/mrc_pkg.sv
// Types shared by the run-control block
package mrc_pkg;
  typedef enum logic [1:0] {
    MRC_IDLE = 2'b00,
    MRC_FETCH = 2'b01,
    MRC_FORM = 2'b10
  } mrc_state_e;
endpackage

// file: verilog/mrc_setting_mem.sv
// Settings store: 32 words of 10 bits, registered read port
`timescale 1ns/10ps
`default_nettype none
`include "mrc_defines.svh"
module mrc_setting_mem
  import mrc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [`MRC_SET_W-1:0] wdata,
  input wire logic [4:0] raddr,
  output logic [`MRC_SET_W-1:0] rdata_q
);
  logic [`MRC_SET_W-1:0] mem_q [0:`MRC_DEV_REGS-1];
  genvar gi;
  // Reset every word so no read ever returns an unknown
  generate
    for (gi = 0; gi < `MRC_DEV_REGS; gi = gi + 1)
    begin : g_word
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          mem_q[gi] <= '0;
        else if (we && (waddr == 5'(gi)))
          mem_q[gi] <= wdata;
      end
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_q <= '0;
    else
      rdata_q <= mem_q[raddr];
  end
endmodule
`default_nettype wire

// file: verilog/mrc_top.sv
// Run-control register bank with fault readback on an AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mrc_defines.svh"
module mrc_top
  import mrc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic direction_pin,
  input wire logic general_fault_flag,
  input wire logic supply_reset_flag,
  input wire logic storage_fault_flag,
  input wire logic timeout_expiry_flag,
  input wire logic soft_current_limit_flag,
  input wire logic nvm_write_limit_flag,
  output logic motor_forward,
  output logic excitation_en,
  output logic run_start,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level counts once stages two and three agree
  localparam int NIN = `MRC_FLT_W + 1;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [`MRC_FLT_W-1:0] fault_q, fault_d, rise;
  logic dir_pin_q;
  assign pin_raw = {direction_pin, general_fault_flag, supply_reset_flag,
                    storage_fault_flag, timeout_expiry_flag,
                    soft_current_limit_flag, nvm_write_limit_flag};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_sync
      assign lvl_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          lvl_q[gi] <= lvl_d[gi];
        end
      end
    end
  endgenerate
  // Bit 5 is the general flag down to bit 0 the write-limit flag
  assign fault_q = lvl_q[`MRC_FLT_W-1:0];
  assign fault_d = lvl_d[`MRC_FLT_W-1:0];
  assign dir_pin_q = lvl_q[NIN-1];
  assign rise = fault_d & ~fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic addr_go, mapped_a, wr_pend_q, wr_go;
  logic [`MRC_IDX_W-1:0] idx_a, idx_q;
  logic idx_dev;
  mrc_state_e state_q, state_d;
  assign addr_go = hsel && hready && (htrans == `MRC_HTRANS_NONSEQ);
  assign mapped_a = (haddr[31:8] == 24'h000000);
  assign idx_a = mapped_a ? haddr[7:2] : `MRC_IDX_CLR + 6'h01;
  assign idx_dev = (idx_q < 6'(`MRC_DEV_REGS));
  assign wr_go = wr_pend_q;

  assign state_d = (state_q == MRC_IDLE) ? ((addr_go && !hwrite) ? MRC_FETCH : MRC_IDLE) :
                   (state_q == MRC_FETCH) ? MRC_FORM : MRC_IDLE;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= MRC_IDLE;
      wr_pend_q <= 1'b0;
      idx_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      wr_pend_q <= addr_go && hwrite;
      if (addr_go)
        idx_q <= idx_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings store, lower ten bits only: the fault field is never stored
  logic mem_we;
  logic [`MRC_SET_W-1:0] mem_rdata;
  assign mem_we = wr_go && idx_dev;
  mrc_setting_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(mem_we),
    .waddr(idx_q[4:0]),
    .wdata(hwdata[`MRC_SET_W-1:0]),
    .raddr(idx_q[4:0]),
    .rdata_q(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  logic run_bit_q, dir_bit_q, run_wr;
  assign run_wr = wr_go && (idx_q == `MRC_IDX_RUN);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_bit_q <= 1'b0;
      dir_bit_q <= 1'b0;
    end
    else if (run_wr)
    begin
      run_bit_q <= hwdata[`MRC_RUN_BIT];
      dir_bit_q <= hwdata[`MRC_DIR_BIT];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      motor_forward <= 1'b1;
      excitation_en <= 1'b0;
      run_start <= 1'b0;
    end
    else
    begin
      motor_forward <= ~(dir_bit_q ^ dir_pin_q);
      excitation_en <= run_bit_q;
      run_start <= run_wr && hwdata[`MRC_RUN_BIT] && !run_bit_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault events; a new fault beats a clear in the same cycle
  logic [`MRC_FLT_W-1:0] sts_q, en_q, clr;
  assign clr = (wr_go && idx_q == `MRC_IDX_CLR) ? hwdata[`MRC_FLT_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sts_q <= '0;
      en_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      sts_q <= (sts_q & ~clr) | rise;
      if (wr_go && idx_q == `MRC_IDX_EN)
        en_q <= hwdata[`MRC_FLT_W-1:0];
      irq <= |(sts_q & en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer: two wait states, memory data is one cycle late
  logic [31:0] rd_word;
  assign rd_word = idx_dev ? {16'h0000, fault_q, mem_rdata} :
                   (idx_q == `MRC_IDX_STS) ? {26'h0000000, sts_q} :
                   (idx_q == `MRC_IDX_EN) ? {26'h0000000, en_q} : 32'h00000000;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      hreadyout <= (state_d == MRC_IDLE);
      if (state_q == MRC_FORM)
        hrdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dir_map;
    @(posedge hclk) disable iff (!hresetn)
    (dir_bit_q == dir_pin_q) |=> motor_forward;
  endproperty
  a_dir_map: assert property (p_dir_map) else $error("direction map wrong");

  property p_run_stop;
    @(posedge hclk) disable iff (!hresetn)
    run_wr && !hwdata[`MRC_RUN_BIT] |=> ##1 !excitation_en;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("excitation not stopped");

  property p_run_start;
    @(posedge hclk) disable iff (!hresetn)
    $rose(run_bit_q) |-> run_start ##1 excitation_en;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run start missing");

  property p_flt_field;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == MRC_FORM) && idx_dev |=> hrdata[`MRC_FLT_MSB:`MRC_FLT_LSB] == $past(fault_q);
  endproperty
  a_flt_field: assert property (p_flt_field) else $error("fault field wrong");

  property p_set_field;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == MRC_FORM) && idx_dev |=> hrdata[`MRC_SET_W-1:0] == $past(mem_rdata);
  endproperty
  a_set_field: assert property (p_set_field) else $error("settings field wrong");

  property p_order_low;
    @(posedge hclk) disable iff (!hresetn)
    (nvm_write_limit_flag == 1'b1)[*5] |-> fault_q[0];
  endproperty
  a_order_low: assert property (p_order_low) else $error("write limit not bit 10");

  property p_flag_level;
    @(posedge hclk) disable iff (!hresetn)
    (general_fault_flag == 1'b0)[*5] |-> !fault_q[5];
  endproperty
  a_flag_level: assert property (p_flag_level) else $error("general flag stuck");

  property p_run_pos;
    @(posedge hclk) disable iff (!hresetn)
    run_wr |=> run_bit_q == $past(hwdata[`MRC_RUN_BIT]) &&
               dir_bit_q == $past(hwdata[`MRC_DIR_BIT]);
  endproperty
  a_run_pos: assert property (p_run_pos) else $error("run register layout wrong");

  property p_flt_ro;
    @(posedge hclk) disable iff (!hresetn)
    wr_go && (fault_d == fault_q) |=> $stable(fault_q);
  endproperty
  a_flt_ro: assert property (p_flt_ro) else $error("write changed fault field");
endmodule
`default_nettype wire
